// ---- pbcs_pkg.sv ----
// pbcs_pkg: register numbers, field positions and reset values of the
// basic control and basic status registers.
// assumes a 16-bit register port addressed by a 5-bit register number.
package pbcs_pkg;
	// ------------------------------------------------------------
	// register numbers
	// ------------------------------------------------------------
	localparam logic [4:0]  REG_BASIC_CONTROL = 5'h00;
	localparam logic [4:0]  REG_BASIC_STATUS  = 5'h01;
	// ------------------------------------------------------------
	// basic control fields
	// ------------------------------------------------------------
	localparam int          CTL_SOFT_RESET    = 15;
	localparam int          CTL_LOOPBACK      = 14;
	localparam int          CTL_SPEED_100     = 13;
	localparam int          CTL_NEG_ENABLE    = 12;
	localparam int          CTL_POWER_DOWN    = 11;
	localparam int          CTL_ISOLATE       = 10;
	localparam int          CTL_NEG_RESTART   = 9;
	localparam int          CTL_FULL_DUPLEX   = 8;
	localparam int          CTL_COL_TEST      = 7;
	// ------------------------------------------------------------
	// basic status: fixed capability word
	// ------------------------------------------------------------
	// t4=0, 100fd=1, 100hd=1, 10fd=1, 10hd=1, reserved 0, no preamble=1,
	// negotiation ability=1, extended capability=1; live bits or-ed in
	localparam logic [15:0] STS_FIXED         = 16'h7849;
	localparam int          STS_NEG_DONE      = 5;
	localparam int          STS_REMOTE_FAULT  = 4;
	localparam int          STS_LINK_UP       = 2;
	localparam int          STS_JABBER        = 1;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic        RST_FULL_DUPLEX   = 1'b1;
	localparam logic [15:0] DATA_ZERO         = 16'h0000;
endpackage

// ---- pbcs_sync.sv ----
// pbcs_sync: three-stage synchroniser for a level from a pin.
// assumes CLK domain; output changes once stages two and three agree.
`timescale 1ns/1ns
module pbcs_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// level
	input  wire logic din,
	output logic      dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	// stages keep sampling through reset so the strap is valid at release
	always_ff @(posedge clk) begin
		s1_q <= din;
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (srst || (s2_q == s3_q)) begin
			out_q <= s3_q;
		end
	end

	assign dout = out_q;
endmodule

// ---- pbcs_regs.sv ----
// pbcs_regs: basic control register and basic status register of a
// 10/100 transceiver, reached through its management register port.
// assumes the serial management engine presents register number,
// write data and a one-cycle write or read strobe on CLK.
//
// Functional notes
// R1 - writing soft reset one resets the device; bit clears itself, reads zero
// R2 - writing restart one restarts negotiation; bit self-clears; zero is normal
// R3 - manual speed: one 100, zero 10; ignored while negotiation enabled
// R4 - negotiation enabled: result overrides speed and duplex; clear disables it
// R5 - leaving power-down by reset needs two writes; first only clears power-down
// R6 - second reset write after power-down exit resets chip and re-samples straps
// R7 - isolate one detaches device from the MAC interface; zero is normal
// R8 - 100 Mbps full-duplex capability bit always reads one
// R9 - 100 Mbps half-duplex capability bit always reads one
// R10 - writes to reserved control bits and capability bits have no effect
`timescale 1ns/1ns
module pbcs_regs (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// management register port
	input  wire logic [4:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [15:0] REG_RDATA,
	output logic             REG_RVALID,
	// strap pin
	input  wire logic        NEGOTIATION_AND_SPEED_STRAP_PIN,
	// live status from the transceiver core
	input  wire logic        NEG_DONE,
	input  wire logic        LINK_UP,
	input  wire logic        REMOTE_FAULT,
	input  wire logic        JABBER,
	// controls toward the transceiver core
	output logic             CHIP_RESET,
	output logic             NEG_RESTART,
	output logic             NEG_ENABLE,
	output logic             SPEED_100,
	output logic             FULL_DUPLEX,
	output logic             POWER_DOWN,
	output logic             ISOLATE,
	output logic             LOOPBACK,
	output logic             COL_TEST
);
	// ------------------------------------------------------------
	// strap sampling
	// ------------------------------------------------------------
	logic strap_sync;

	pbcs_sync u_strap (
		.clk  (CLK),
		.srst (SRST),
		.din  (NEGOTIATION_AND_SPEED_STRAP_PIN),
		.dout (strap_sync)
	);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic        ctl_sel;
	logic        sts_sel;
	logic        wr_ctl;
	logic        reset_req;
	logic        full_reset;
	logic        pd_exit;
	logic        reload;
	logic [15:0] ctl_word;
	logic [15:0] sts_word;
	logic [15:0] rd_mux;

	assign ctl_sel  = (REG_ADDR == pbcs_pkg::REG_BASIC_CONTROL);
	assign sts_sel  = (REG_ADDR == pbcs_pkg::REG_BASIC_STATUS);
	assign wr_ctl   = REG_WR && ctl_sel;
	assign reset_req = wr_ctl && REG_WDATA[pbcs_pkg::CTL_SOFT_RESET];

	// control state
	logic pd_q;
	logic pend_q;
	logic neg_en_q;
	logic speed_q;
	logic duplex_q;
	logic iso_q;
	logic lpbk_q;
	logic col_q;
	logic strap_load_q;
	logic chip_rst_q;
	logic restart_q;

	// first reset write while powered down only leaves power-down
	assign pd_exit    = reset_req && pd_q; // R5
	// second reset write (or any reset write outside power-down) performs a full reset
	assign full_reset = reset_req && !pd_q; // R1 R6
	// straps reloaded after reset release and after every full reset
	assign reload     = strap_load_q; // R6

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST || full_reset) begin
			pd_q         <= 1'b0;
			neg_en_q     <= 1'b0;
			speed_q      <= 1'b0;
			duplex_q     <= pbcs_pkg::RST_FULL_DUPLEX;
			iso_q        <= 1'b0;
			lpbk_q       <= 1'b0;
			col_q        <= 1'b0;
			strap_load_q <= 1'b1; // R6
		end else if (pd_exit) begin
			pd_q         <= 1'b0; // R5
			strap_load_q <= 1'b0;
		end else begin
			strap_load_q <= 1'b0;
			if (reload) begin
				// strap gives both negotiation enable and speed
				neg_en_q <= strap_sync;
				speed_q  <= strap_sync;
			end
			if (wr_ctl) begin
				// reserved low bits have no storage
				lpbk_q   <= REG_WDATA[pbcs_pkg::CTL_LOOPBACK]; // R10
				speed_q  <= REG_WDATA[pbcs_pkg::CTL_SPEED_100];
				neg_en_q <= REG_WDATA[pbcs_pkg::CTL_NEG_ENABLE]; // R4
				pd_q     <= REG_WDATA[pbcs_pkg::CTL_POWER_DOWN];
				iso_q    <= REG_WDATA[pbcs_pkg::CTL_ISOLATE]; // R7
				duplex_q <= REG_WDATA[pbcs_pkg::CTL_FULL_DUPLEX];
				col_q    <= REG_WDATA[pbcs_pkg::CTL_COL_TEST];
			end
		end
	end

	// pend_q marks a power-down exit done, awaiting the second reset write
	always_ff @(posedge CLK) begin
		if (SRST || full_reset) begin
			pend_q <= 1'b0;
		end else if (pd_exit) begin
			pend_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// self-clearing pulses
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			chip_rst_q <= 1'b0;
			restart_q  <= 1'b0;
		end else begin
			chip_rst_q <= full_reset; // R1 R6
			// restart pulses once; the stored bit never reads back one
			restart_q  <= wr_ctl && !reset_req && !pd_q
				&& REG_WDATA[pbcs_pkg::CTL_NEG_RESTART]; // R2
		end
	end

	// ------------------------------------------------------------
	// effective mode: negotiation overrides manual speed and duplex
	// ------------------------------------------------------------
	logic spd_q;
	logic dpx_q;
	logic nen_q;
	logic pdo_q;
	logic iso_o_q;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			spd_q   <= 1'b0;
			dpx_q   <= 1'b0;
			nen_q   <= 1'b0;
			pdo_q   <= 1'b0;
			iso_o_q <= 1'b0;
		end else begin
			nen_q   <= neg_en_q;
			// manual bits only drive the core when negotiation is off
			spd_q   <= neg_en_q ? 1'b0 : speed_q; // R3 R4
			dpx_q   <= neg_en_q ? 1'b0 : duplex_q; // R4
			pdo_q   <= pd_q;
			iso_o_q <= iso_q; // R7
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		ctl_word = pbcs_pkg::DATA_ZERO; // R1 R2 R10
		ctl_word[pbcs_pkg::CTL_LOOPBACK]    = lpbk_q;
		ctl_word[pbcs_pkg::CTL_SPEED_100]   = speed_q;
		ctl_word[pbcs_pkg::CTL_NEG_ENABLE]  = neg_en_q;
		ctl_word[pbcs_pkg::CTL_POWER_DOWN]  = pd_q;
		ctl_word[pbcs_pkg::CTL_ISOLATE]     = iso_q;
		ctl_word[pbcs_pkg::CTL_FULL_DUPLEX] = duplex_q;
		ctl_word[pbcs_pkg::CTL_COL_TEST]    = col_q;
		sts_word = pbcs_pkg::STS_FIXED; // R8 R9 R10
		sts_word[pbcs_pkg::STS_NEG_DONE]     = NEG_DONE;
		sts_word[pbcs_pkg::STS_REMOTE_FAULT] = REMOTE_FAULT;
		sts_word[pbcs_pkg::STS_LINK_UP]      = LINK_UP;
		sts_word[pbcs_pkg::STS_JABBER]       = JABBER;
	end

	assign rd_mux = ctl_sel ? ctl_word : (sts_sel ? sts_word : pbcs_pkg::DATA_ZERO);

	logic [15:0] rdata_q;
	logic        rvalid_q;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_q  <= pbcs_pkg::DATA_ZERO;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= REG_RD;
			if (REG_RD) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign REG_RDATA   = rdata_q;
	assign REG_RVALID  = rvalid_q;
	assign CHIP_RESET  = chip_rst_q;
	assign NEG_RESTART = restart_q;
	assign NEG_ENABLE  = nen_q;
	assign SPEED_100   = spd_q;
	assign FULL_DUPLEX = dpx_q;
	assign POWER_DOWN  = pdo_q;
	assign ISOLATE     = iso_o_q;
	assign LOOPBACK    = lpbk_q;
	assign COL_TEST    = col_q;
endmodule

// ---- pbcs_mgmt.sv ----
// pbcs_mgmt: management controller model driving the register port.
// assumes pbcs_regs timing: strobe taken at CLK rise, answer a cycle later.
`timescale 1ns/1ns
module pbcs_mgmt (
	// clock
	input  logic        clk,
	// register port
	output logic [4:0]  addr,
	output logic [15:0] wdata,
	output logic        wr,
	output logic        rd,
	input  logic [15:0] rdata,
	input  logic        rvalid
);
	initial begin
		addr = 5'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
		// scrambled so nothing leans on a stale word
		wdata = ~d;
	endtask
	task rd_reg(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		// no answer gives a wrong word, so the bench sees it
		d = (rvalid === 1'b1) ? rdata : ~rdata;
	endtask
endmodule

// ---- pbcs_regs_assertions.sv ----
// pbcs_regs_assertions: port checks on the control and status bank.
// assumes bind into pbcs_regs; one CLK domain, SRST sync active high.
`timescale 1ns/1ns
module pbcs_regs_assertions (
	// clock and reset
	input logic        CLK,
	input logic        SRST,
	// register port
	input logic [4:0]  REG_ADDR,
	input logic [15:0] REG_WDATA,
	input logic        REG_WR,
	input logic        REG_RD,
	input logic [15:0] REG_RDATA,
	input logic        REG_RVALID,
	// controls
	input logic        CHIP_RESET,
	input logic        NEG_RESTART,
	input logic        NEG_ENABLE,
	input logic        SPEED_100,
	input logic        FULL_DUPLEX,
	input logic        POWER_DOWN,
	input logic        ISOLATE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	wire ctl_wr = REG_WR && REG_ADDR == 5'h00;
	wire rst_wr = ctl_wr && REG_WDATA[15];
	a_soft_reset: assert property (rst_wr && !POWER_DOWN && !$past(REG_WR) |=> CHIP_RESET)
		else $error("soft reset write gave no chip reset");
	a_pd_first_wr: assert property (rst_wr && POWER_DOWN && !$past(REG_WR)
		|=> !CHIP_RESET ##1 !POWER_DOWN)
		else $error("reset write in power-down misbehaved");
	a_restart_neg: assert property (ctl_wr && REG_WDATA[9] && !REG_WDATA[15] && !REG_WDATA[11]
		&& !POWER_DOWN && !$past(REG_WR) |=> NEG_RESTART)
		else $error("restart write gave no restart pulse");
	a_pulse_once: assert property ((NEG_RESTART || CHIP_RESET) && !REG_WR
		|=> !NEG_RESTART && !CHIP_RESET)
		else $error("self-clearing pulse held");
	a_manual_ignored: assert property (NEG_ENABLE |-> !SPEED_100 && !FULL_DUPLEX)
		else $error("manual speed or duplex used while negotiating");
	a_isolate_follow: assert property ((ctl_wr && !REG_WDATA[15] && !$past(REG_WR)) ##1 !REG_WR
		|=> ISOLATE == $past(REG_WDATA[10], 2))
		else $error("isolate output does not follow control bit");
	a_ctl_fixed: assert property (REG_RD && REG_ADDR == 5'h00 |=> REG_RVALID && !REG_RDATA[15]
		&& !REG_RDATA[9] && REG_RDATA[6:0] == 7'h00)
		else $error("fixed control bits read wrong");
	a_status_caps: assert property (REG_RD && REG_ADDR == 5'h01
		|=> REG_RVALID && REG_RDATA[14:13] == 2'b11)
		else $error("100 Mbps capability bits read wrong");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR > 5'h01 |=> REG_RDATA == 16'h0000)
		else $error("unmapped register read not zero");
	c_chip_reset: cover property (CHIP_RESET);
	c_pd_exit: cover property (rst_wr && POWER_DOWN);
	c_restart: cover property (NEG_RESTART);
endmodule
bind pbcs_regs pbcs_regs_assertions chk (.*);

// ---- phy_basic_control_status_regs_bench.sv ----
// bench: random and corner writes and reads of the control/status bank.
// assumes pbcs_regs, pbcs_mgmt and the bound checker are compiled first.
`timescale 1ns/1ns
module phy_basic_control_status_regs_bench;
	logic clk = 1'b0, srst = 1'b1, strap = 1'b0, wr, rd, rvalid;
	logic [3:0] live = 4'h0;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, d, e;
	logic chip_rst, neg_rst, neg_en, spd, fdx, pd, iso, lb, col;
	int err_count = 0, num_checks = 0, seed = 94;
	always #20 clk = ~clk;
	pbcs_regs uut (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.NEGOTIATION_AND_SPEED_STRAP_PIN(strap), .NEG_DONE(live[3]), .LINK_UP(live[2]),
		.REMOTE_FAULT(live[1]), .JABBER(live[0]), .CHIP_RESET(chip_rst), .NEG_RESTART(neg_rst),
		.NEG_ENABLE(neg_en), .SPEED_100(spd), .FULL_DUPLEX(fdx), .POWER_DOWN(pd),
		.ISOLATE(iso), .LOOPBACK(lb), .COL_TEST(col));
	pbcs_mgmt m (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rvalid(rvalid));
	function automatic logic [15:0] sts(input logic [3:0] l);
		return 16'h7849 | {10'h000, l[3], l[1], 1'b0, l[2], l[0], 1'b0};
	endfunction
	task check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 srst = 1'b0;
		m.rd_reg(5'h00, d);
		check(d, 16'h0100);
		live = 4'($random(seed));
		m.wr_reg(5'h01, 16'hffff);
		m.rd_reg(5'h01, d);
		check(d, sts(live));
		$display("test reset_status done");
		for (int i = 0; i < 24; i++) begin
			// corner words first: all writable bits but soft reset and power-down, then none
			d = (i == 0) ? 16'h77ff : (i == 1) ? 16'h0000 : 16'($random(seed)) & 16'h77ff;
			m.wr_reg(5'h00, d);
			m.wr_reg(5'h02 + i[4:0], ~d);
			m.rd_reg(5'h00, e);
			check(e, d & 16'h7d80);
			check(16'({col, lb, fdx, spd, neg_en, iso, pd}), 16'({d[7], d[14], d[8] & ~d[12],
				d[13] & ~d[12], d[12], d[10], d[11]}));
			m.rd_reg(5'h02 + i[4:0], e);
			check(e, 16'h0000);
			live = 4'($random(seed));
			m.rd_reg(5'h01, e);
			check(e, sts(live));
		end
		$display("test random_control done");
		// mid-run reset: manual full duplex is the only output left high
		@(posedge clk);
		#1 srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		m.rd_reg(5'h00, d);
		check(d, 16'h0100);
		check(16'({chip_rst, neg_rst, neg_en, spd, fdx, pd, iso, lb, col}), 16'h0010);
		$display("test mid_reset done");
		m.wr_reg(5'h00, 16'h0c00);
		repeat (2) @(posedge clk);
		m.wr_reg(5'h00, 16'h8000);
		check(16'(chip_rst), 16'h0000);
		m.rd_reg(5'h00, d);
		check(d, 16'h0400);
		strap = 1'b1;
		repeat (8) @(posedge clk);
		m.wr_reg(5'h00, 16'h8000);
		check(16'(chip_rst), 16'h0001);
		repeat (3) @(posedge clk);
		m.rd_reg(5'h00, d);
		check(d, 16'h3100);
		m.wr_reg(5'h00, 16'h1200);
		check(16'(neg_rst), 16'h0001);
		m.rd_reg(5'h00, d);
		check(d, 16'h1000);
		$display("test power_down_restart done");
		results;
	end
	initial begin
		// whole run is well under 1000 cycles
		#400000;
		err_count++;
		results;
	end
endmodule
